// file: shared/dac_loader_defines.svh
`ifndef DAC_LOADER_DEFINES_SVH
`define DAC_LOADER_DEFINES_SVH

// serial word layout
`define WORD_BITS        16
`define CODE_MSB         11
`define SPEED_BIT        14
`define POWER_BIT        13
`define CODE_RESET       12'h000
`define CNT_RESET        5'h00
`define CNT_FULL         5'h10
`define WORD_RESET       16'h0000
`define CNT_STEP         5'h01
`define CTL_RESET        1'b0

// synchronised pins idle high out of reset
`define PIN_IDLE         1'b1
`define SYNC_IDLE        4'hf

`endif

// file: shared/dac_loader_pkg.sv
package dac_loader_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE  = 3'b100
    } load_state_t;
endpackage

// file: rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for a group of pin inputs
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             sys_clk_i,
    input  wire logic             nrst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // an empty pin group has nothing to synchronise
    if (WIDTH < 1) begin : g_width_check
        $error("synchroniser needs at least one pin");
    end

    // first stage read only by the second
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= INIT;
            sync_q <= INIT;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // pin_sync
`default_nettype wire

// file: rtl/serial_dac_word_loader.sv
`include "dac_loader_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module serial_dac_word_loader #(
    parameter int WORD_BITS = `WORD_BITS
) (
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        dev_select_n_i,
    input  wire logic        frame_sync_n_i,
    input  wire logic        serial_clk_i,
    input  wire logic        serial_data_i,
    output logic [11:0]      dac_code_o,
    output logic             settle_speed_sel_o,
    output logic             power_down_ctl_o,
    output logic             latch_update_o
);
    import dac_loader_pkg::*;

    // the shifter, counter and field positions serve a sixteen-bit word only
    if (WORD_BITS != `WORD_BITS) begin : g_word_bits_check
        $error("serial word must be sixteen bits");
    end

    // the control fields must sit above the code and inside the word
    if (`SPEED_BIT >= `WORD_BITS || `POWER_BIT <= `CODE_MSB) begin : g_field_check
        $error("latch fields do not fit the serial word");
    end

    // a level that went from high to low between two samples
    function automatic logic fell_edge(input logic prev, input logic now);
        fell_edge = prev & ~now;
    endfunction

    // a level that went from low to high between two samples
    function automatic logic rose_edge(input logic prev, input logic now);
        rose_edge = ~prev & now;
    endfunction

    // pack speed, power and code out of a received word; the two spare
    // control bits carry nothing for this block and are dropped here
    function automatic logic [13:0] latch_fields(input logic [15:0] rx_word);
        latch_fields = {rx_word[`SPEED_BIT], rx_word[`POWER_BIT], rx_word[`CODE_MSB:0]};
    endfunction

    // synced pin levels
    logic [3:0] pins_s;
    logic       sel_n;
    logic       fs_n;
    logic       sclk;
    logic       sdat;

    // all pins pass two flops before use; select, frame, clock and data share
    // one synchroniser so that their relative order survives the crossing, and
    // each serial clock phase must span more than one system clock to be seen;
    // the flops idle high so that reset shows no frame edge
    pin_sync #(.WIDTH(4), .INIT(`SYNC_IDLE)) u_sync (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .async_i   ({dev_select_n_i, frame_sync_n_i, serial_clk_i, serial_data_i}),
        .sync_o    (pins_s)
    );
    assign sel_n = pins_s[3];
    assign fs_n  = pins_s[2];
    assign sclk  = pins_s[1];
    assign sdat  = pins_s[0];

    // frame tracking state
    load_state_t state_q, state_d;
    logic [15:0] shift_q, shift_d;
    logic [4:0]  cnt_q, cnt_d;
    logic        load_req;

    // edge history of the synced frame and clock levels
    logic        fs_n_q, fs_n_d;
    logic        sclk_q, sclk_d;
    logic        fs_fall;
    logic        fs_rise;
    logic        sclk_fall;
    logic        sclk_rise;

    // converter latch and its update strobe
    logic [11:0] code_q, code_d;
    logic        speed_q, speed_d;
    logic        pwr_q, pwr_d;
    logic        upd_q, upd_d;

    // levels are followed even while deselected, so that a reselect
    // never presents an edge that happened while the device was away
    always_comb begin
        fs_n_d = fs_n;
        sclk_d = sclk;
    end

    // edge history starts at the idle-high level of the synchroniser
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fs_n_q <= `PIN_IDLE;
            sclk_q <= `PIN_IDLE;
        end else begin
            fs_n_q <= fs_n_d;
            sclk_q <= sclk_d;
        end
    end

    // one-cycle strobes for each synced frame and clock pin edge
    assign fs_fall   = fell_edge(fs_n_q, fs_n);
    assign fs_rise   = rose_edge(fs_n_q, fs_n);
    assign sclk_fall = fell_edge(sclk_q, sclk);
    assign sclk_rise = rose_edge(sclk_q, sclk);

    // framing and shifting; load_req asks the latch group for an update
    // the counter reaches its full value only on the way into ST_DONE
    always_comb begin
        state_d  = state_q;
        shift_d  = shift_q;
        cnt_d    = cnt_q;
        load_req = 1'b0;
        // deselected: nothing moves, an open word resumes on reselect
        if (!sel_n) begin
            unique case (state_q)
                ST_IDLE: begin
                    // clock falls before the frame fall are ignored here
                    if (fs_fall) begin
                        cnt_d   = `CNT_RESET;
                        state_d = ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    // a frame rise ends a short word with what is in the shifter
                    if (fs_rise) begin
                        load_req = 1'b1;
                        state_d  = ST_IDLE;
                    end else if (sclk_fall) begin
                        shift_d = {shift_q[`WORD_BITS-2:0], sdat};
                        cnt_d   = cnt_q + `CNT_STEP;
                        if (cnt_q == `CNT_FULL - `CNT_STEP) begin
                            state_d = ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    // all bits in: the next clock rise or a frame rise loads
                    if (sclk_rise || fs_rise) begin
                        load_req = 1'b1;
                        state_d  = ST_IDLE;
                    end
                end
                default: state_d = ST_IDLE;
            endcase
            // a new frame restarts the count, even in the middle of a word
            if (fs_fall) begin
                cnt_d   = `CNT_RESET;
                state_d = ST_SHIFT;
            end
        end
    end

    // frame registers, cleared at power on; the shifter keeps its bits
    // after a load, so a short word reuses the older ones above it
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_IDLE;
            shift_q <= `WORD_RESET;
            cnt_q   <= `CNT_RESET;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
        end
    end

    // all fields load together, so code and controls never mix two words;
    // the update lands about three system clocks after the pin edge that
    // causes it, two in the synchroniser and one in the latch flops
    always_comb begin
        code_d  = code_q;
        speed_d = speed_q;
        pwr_d   = pwr_q;
        upd_d   = load_req;
        if (load_req) begin
            {speed_d, pwr_d, code_d} = latch_fields(shift_q);
        end
    end

    // converter latch, cleared at power on
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            code_q  <= `CODE_RESET;
            speed_q <= `CTL_RESET;
            pwr_q   <= `CTL_RESET;
            upd_q   <= `CTL_RESET;
        end else begin
            code_q  <= code_d;
            speed_q <= speed_d;
            pwr_q   <= pwr_d;
            upd_q   <= upd_d;
        end
    end

    // outputs come straight from the latch flops
    assign dac_code_o         = code_q;
    assign settle_speed_sel_o = speed_q;
    assign power_down_ctl_o   = pwr_q;
    assign latch_update_o     = upd_q;
endmodule // serial_dac_word_loader
`default_nettype wire

// file: bench/dac_loader_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dac_loader_properties (
    input wire logic        sys_clk_i,
    input wire logic        nrst_i,
    input wire logic        dev_select_n_i,
    input wire logic        frame_sync_n_i,
    input wire logic        serial_clk_i,
    input wire logic        settle_speed_sel_o,
    input wire logic        power_down_ctl_o,
    input wire logic        latch_update_o,
    input wire logic [11:0] dac_code_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // no frame or clock pin edge in a cycle
    sequence s_quiet; $stable(frame_sync_n_i) && $stable(serial_clk_i); endsequence
    AST_RST: assert property ($rose(nrst_i) |-> !{dac_code_o, settle_speed_sel_o, power_down_ctl_o})
        else $error("outputs not clear");
    AST_CODE: assert property (!latch_update_o |-> $stable(dac_code_o)) else $error("code moved");
    AST_CTL: assert property (!latch_update_o |-> $stable({settle_speed_sel_o, power_down_ctl_o}))
        else $error("ctl moved");
    AST_GAP: assert property (latch_update_o |=> !latch_update_o [*3]) else $error("pulse");
    AST_DESEL: assert property (dev_select_n_i [*6] |-> !latch_update_o) else $error("desel");
    AST_CAUSE: assert property (latch_update_o |-> $past(serial_clk_i, 3) || $past(frame_sync_n_i, 3))
        else $error("cause");
    AST_QUIET: assert property (s_quiet [*6] |-> !latch_update_o) else $error("quiet");
    AST_FRESH: assert property (frame_sync_n_i [*8] ##1 !frame_sync_n_i |-> !latch_update_o [*3])
        else $error("fresh");
endmodule // dac_loader_properties
`default_nettype wire

// file: bench/host_serial_port.sv
`timescale 1ns/10ps
`default_nettype none
// host port, moves on falling system edges
module host_serial_port (
    input  wire logic clk_i,
    output logic      sel_n_o,
    output logic      fs_n_o,
    output logic      sclk_o,
    output logic      sd_o
);
    initial {sel_n_o, fs_n_o, sclk_o, sd_o} = 4'b1100;
    task automatic hold(input int n); repeat (n) @(negedge clk_i); endtask
    // one 400 ns link clock, bit held across the fall
    task automatic tick(input logic b); sd_o = b; sclk_o = 1'b1; hold(4); sclk_o = 1'b0; hold(4); endtask
    // mode 1 drops select mid word, 2 never selects, 3 keeps select low
    task automatic send(input logic [15:0] w, input int n, gap, mode);
        sel_n_o = (mode == 2); hold(gap);
        fs_n_o = 1'b0; hold(gap);
        for (int i = 15; i > 15 - n; i--) begin
            if (mode == 1 && i == 7) begin
                sel_n_o = 1'b1; hold(4);
                repeat (3) tick(~w[i]);
                sel_n_o = 1'b0; hold(4);
            end
            tick(w[i]);
        end
        // the rise after the sixteenth fall loads; a short word waits for the frame rise
        if (n == 16) begin
            sd_o = ~sd_o;
            sclk_o = 1'b1;
            hold(4);
            sclk_o = 1'b0;
        end
        hold(gap);
        fs_n_o = 1'b1; hold(gap);
        sel_n_o = (mode != 3); hold(8);
    endtask
endmodule // host_serial_port
`default_nettype wire

// file: bench/tb_serial_dac_word_loader.sv
`timescale 1ns/10ps
`default_nettype none
module tb_serial_dac_word_loader;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, dev_select_n_i, frame_sync_n_i, serial_clk_i, serial_data_i;
    logic settle_speed_sel_o, power_down_ctl_o, latch_update_o;
    logic [11:0] dac_code_o;
    wire logic [13:0] outs = {settle_speed_sel_o, power_down_ctl_o, dac_code_o};
    int n_mismatch = 0, samples_checked = 0;
    int n_upd = 0, upd_at_fs = 0;
    host_serial_port u_host (.clk_i(sys_clk_i), .sel_n_o(dev_select_n_i), .fs_n_o(frame_sync_n_i),
        .sclk_o(serial_clk_i), .sd_o(serial_data_i));
    serial_dac_word_loader u_dut (
        .sys_clk_i          (sys_clk_i),
        .nrst_i             (nrst_i),
        .dev_select_n_i     (dev_select_n_i),
        .frame_sync_n_i     (frame_sync_n_i),
        .serial_clk_i       (serial_clk_i),
        .serial_data_i      (serial_data_i),
        .dac_code_o         (dac_code_o),
        .settle_speed_sel_o (settle_speed_sel_o),
        .power_down_ctl_o   (power_down_ctl_o),
        .latch_update_o     (latch_update_o)
    );
    // update pulses so far, and how many had landed when the frame pin rose
    always @(posedge sys_clk_i) if (latch_update_o) n_upd <= n_upd + 1;
    always @(posedge frame_sync_n_i) upd_at_fs <= n_upd;
    initial forever #25 sys_clk_i = ~sys_clk_i;
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [13:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask
    // one word, then compare speed, power and code, the update count and when it landed
    task automatic word(input logic [15:0] w, input int n, m, input logic [13:0] e);
        int u0;
        u0 = n_upd;
        u_host.send(w, n, 3 + 3 * m, m);
        check("latch", outs, e);
        check("update_count", 14'(n_upd - u0), (m == 2) ? 14'h0000 : 14'h0001);
        check("early_update", 14'(upd_at_fs - u0), (m == 2 || n < 16) ? 14'h0000 : 14'h0001);
    endtask
    task automatic t_reset; check("latch", outs, 14'h0000); endtask
    task automatic t_fields; word(16'h4fff, 16, 0, 14'h2fff); word(16'h9000, 16, 0, 14'h0000); endtask
    task automatic t_power; word(16'h2a5c, 16, 0, 14'h1a5c); endtask
    // stale bits after four, then a clean word
    task automatic t_short; word(16'hb000, 4, 0, 14'h15cb); word(16'h0001, 16, 0, 14'h0001); endtask
    task automatic t_select; word(16'h6123, 16, 1, 14'h3123); word(16'h0456, 16, 2, 14'h3123); endtask
    task automatic t_three; word(16'h4800, 16, 3, 14'h2800); word(16'h07ff, 16, 3, 14'h07ff); endtask
    initial begin
        repeat (16) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        t_reset;
        t_fields;
        t_power;
        t_short;
        t_select;
        t_three;
        stop_test;
    end
endmodule // tb_serial_dac_word_loader
bind serial_dac_word_loader dac_loader_properties u_props (
    .sys_clk_i          (sys_clk_i),
    .nrst_i             (nrst_i),
    .dev_select_n_i     (dev_select_n_i),
    .frame_sync_n_i     (frame_sync_n_i),
    .serial_clk_i       (serial_clk_i),
    .settle_speed_sel_o (settle_speed_sel_o),
    .power_down_ctl_o   (power_down_ctl_o),
    .latch_update_o     (latch_update_o),
    .dac_code_o         (dac_code_o)
);
`default_nettype wire
